/* File: hw/pwg_regs.sv */
// pwm period, duty and pin route registers with counter and output stage
// Function
// - period low byte is bits 7:0 of the 16-bit period value.
// - period high byte is bits 15:8 of the shared period value.
// - channel 0 duty high and low bytes form output 0 duty.
// - channel 1 duty high and low bytes form output 1 duty.
// - channel 2 duty high and low bytes form output 2 duty.
// - channel 3 duty high and low bytes form output 3 duty.
// - channel 4 duty high and low bytes form output 4 duty.
// - channel 5 duty high and low bytes form output 5 duty.
// - channel 4 and 5 duty bytes live only in alternate page 1.
// - period and all duty bytes reset to zero.
// - route bit 5 puts channel 5 onto port 0 bit 3.
// - route bit 4 puts channel 4 onto port 0 bit 1.
// - route bit 3 puts channel 3 onto port 0 bit 0.
// - route bit 2 puts channel 2 onto port 1 bit 0.
// - route bit 1 puts channel 1 onto port 1 bit 1.
// - route bit 0 puts channel 0 onto port 1 bit 2.
// - route register resets to zero; upper two bits unused.
// - new values apply after load request at period end, or at once while stopped; request self-clears.
// - edge type counts zero to period and wraps; output high below duty.
// - center type counts up then down; clear on up match, set on down.
// - complementary mode drives odd outputs as inverse of even outputs.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module pwg_regs
    import pwg_pkg::*;
#(
    parameter int CHANNELS = PWG_CHANNELS
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               ce_in,
    input  wire pwg_bus_req_s       bus_req_in,
    input  wire logic [ROUTE_W-1:0] port_data_in,
    output logic      [7:0]         rd_data_out,
    output logic      [5:0]         gen_out,
    output logic      [ROUTE_W-1:0] pin_out
);

    // address decode shared by write and read paths
    function automatic pwg_sel_s dec_addr(input logic [7:0] addr, input logic page1);
        pwg_sel_s s;
        s.kind = SEL_NONE;
        s.chan = 3'h0;
        case (addr)
            PERIOD_LOW_OFF:  s.kind = SEL_PERIOD_LO;
            PERIOD_HIGH_OFF: s.kind = SEL_PERIOD_HI;
            CHAN0_LOW_OFF:   begin s.kind = SEL_DUTY_LO; s.chan = 3'h0; end
            CHAN0_HIGH_OFF:  begin s.kind = SEL_DUTY_HI; s.chan = 3'h0; end
            CHAN1_LOW_OFF:   begin s.kind = SEL_DUTY_LO; s.chan = 3'h1; end
            CHAN1_HIGH_OFF:  begin s.kind = SEL_DUTY_HI; s.chan = 3'h1; end
            CHAN2_LOW_OFF:   begin s.kind = SEL_DUTY_LO; s.chan = 3'h2; end
            CHAN2_HIGH_OFF:  begin s.kind = SEL_DUTY_HI; s.chan = 3'h2; end
            CHAN3_LOW_OFF:   begin s.kind = SEL_DUTY_LO; s.chan = 3'h3; end
            CHAN3_HIGH_OFF:  begin s.kind = SEL_DUTY_HI; s.chan = 3'h3; end
            ROUTE_OFF:       s.kind = SEL_ROUTE;
            CTRL_OFF:        s.kind = SEL_CTRL;
            CONFIG_OFF:      begin s.kind = SEL_MISC; s.chan = 3'h0; end
            PAGE_OFF:        begin s.kind = SEL_MISC; s.chan = 3'h1; end
            // page 1 only; page 0 leaves these unmapped
            CHAN4_LOW_OFF:   if (page1) begin s.kind = SEL_DUTY_LO; s.chan = 3'h4; end
            CHAN4_HIGH_OFF:  if (page1) begin s.kind = SEL_DUTY_HI; s.chan = 3'h4; end
            CHAN5_LOW_OFF:   if (page1) begin s.kind = SEL_DUTY_LO; s.chan = 3'h5; end
            CHAN5_HIGH_OFF:  if (page1) begin s.kind = SEL_DUTY_HI; s.chan = 3'h5; end
            default:         s.kind = SEL_NONE;
        endcase
        return s;
    endfunction : dec_addr

    logic [7:0]         duty_lo_reg [CHANNELS];
    logic [7:0]         duty_hi_reg [CHANNELS];
    logic [15:0]        duty_act_reg [CHANNELS];
    logic [7:0]         period_lo_reg;
    logic [7:0]         period_hi_reg;
    logic [15:0]        period_act_reg;
    logic [ROUTE_W-1:0] route_reg;
    logic               run_reg;
    logic               load_pend_reg;
    logic               clear_pend_reg;
    logic               type_center_reg;
    pwg_mode_e          mode_reg;
    logic               page_reg;
    logic [15:0]        cnt_reg;
    logic [15:0]        cnt_next;
    pwg_cnt_e           dir_reg;
    pwg_cnt_e           dir_next;
    logic [5:0]         gen_next;
    logic [5:0]         raw_gen;
    logic               period_end;
    logic               load_apply;
    pwg_sel_s           wsel;
    pwg_sel_s           rsel;
    logic [7:0]         rd_next;

    assign wsel = dec_addr(bus_req_in.addr, page_reg);
    assign rsel = dec_addr(bus_req_in.addr, page_reg);

    // end of a pwm period: top in edge type, bottom on the way down in center type
    assign period_end = run_reg && (type_center_reg ?
                        (dir_reg == CNT_DOWN && cnt_reg == 16'h0000) ||
                        (period_act_reg == 16'h0000) :
                        (cnt_reg == period_act_reg));
    // buffered values move over at period end, or at once while idle
    assign load_apply = load_pend_reg && (period_end || !run_reg);

    // period and duty byte storage written by software
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            period_lo_reg <= BYTE_RESET;
            period_hi_reg <= BYTE_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                duty_lo_reg[i] <= BYTE_RESET;
                duty_hi_reg[i] <= BYTE_RESET;
            end
        end else if (ce_in && bus_req_in.wr) begin
            case (wsel.kind)
                SEL_PERIOD_LO: period_lo_reg <= bus_req_in.wdata;
                SEL_PERIOD_HI: period_hi_reg <= bus_req_in.wdata;
                SEL_DUTY_LO:   duty_lo_reg[wsel.chan] <= bus_req_in.wdata;
                SEL_DUTY_HI:   duty_hi_reg[wsel.chan] <= bus_req_in.wdata;
                default:       ;
            endcase
        end
    end

    // active period and duty copies used by the counter compare
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            period_act_reg <= 16'h0000;
            for (int i = 0; i < CHANNELS; i++) begin
                duty_act_reg[i] <= 16'h0000;
            end
        end else if (ce_in && load_apply) begin
            period_act_reg <= {period_hi_reg, period_lo_reg};
            for (int i = 0; i < CHANNELS; i++) begin
                duty_act_reg[i] <= {duty_hi_reg[i], duty_lo_reg[i]};
            end
        end
    end

    // route, configuration and page select
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            route_reg       <= ROUTE_RESET;
            type_center_reg <= 1'b0;
            mode_reg        <= MODE_INDEP;
            page_reg        <= 1'b0;
        end else if (ce_in && bus_req_in.wr) begin
            if (wsel.kind == SEL_ROUTE) begin
                route_reg <= bus_req_in.wdata[ROUTE_W-1:0];
            end
            if (wsel.kind == SEL_MISC && wsel.chan == 3'h0) begin
                type_center_reg <= bus_req_in.wdata[CONFIG_TYPE_BIT];
                mode_reg        <= pwg_mode_e'(bus_req_in.wdata[CONFIG_MODE_LSB +: 2]);
            end
            if (wsel.kind == SEL_MISC && wsel.chan == 3'h1) begin
                page_reg <= bus_req_in.wdata[PAGE_BIT];
            end
        end
    end

    // control: run enable, self-clearing load and counter-clear requests
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_reg        <= 1'b0;
            load_pend_reg  <= 1'b0;
            clear_pend_reg <= 1'b0;
        end else if (ce_in) begin
            if (load_apply) begin
                load_pend_reg <= 1'b0;
            end
            if (clear_pend_reg) begin
                clear_pend_reg <= 1'b0;
            end
            // software set wins over the hardware clear
            if (bus_req_in.wr && wsel.kind == SEL_CTRL) begin
                run_reg <= bus_req_in.wdata[CTRL_RUN_BIT];
                if (bus_req_in.wdata[CTRL_LOAD_BIT]) begin
                    load_pend_reg <= 1'b1;
                end
                if (bus_req_in.wdata[CTRL_CLEAR_BIT]) begin
                    clear_pend_reg <= 1'b1;
                end
            end
        end
    end

    // next counter value and direction
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        if (clear_pend_reg) begin
            cnt_next = 16'h0000;
            dir_next = run_reg ? CNT_UP : CNT_IDLE;
        end else if (!run_reg) begin
            dir_next = CNT_IDLE;
        end else begin
            case (dir_reg)
                CNT_IDLE: begin
                    dir_next = CNT_UP;
                end
                CNT_UP: begin
                    if (cnt_reg >= period_act_reg) begin
                        if (type_center_reg && period_act_reg != 16'h0000) begin
                            cnt_next = 16'(cnt_reg - 16'h0001);
                            dir_next = CNT_DOWN;
                        end else begin
                            cnt_next = 16'h0000;
                        end
                    end else begin
                        cnt_next = 16'(cnt_reg + 16'h0001);
                    end
                end
                CNT_DOWN: begin
                    if (cnt_reg == 16'h0000) begin
                        cnt_next = 16'h0001;
                        dir_next = CNT_UP;
                    end else begin
                        cnt_next = 16'(cnt_reg - 16'h0001);
                    end
                end
                default: begin
                    dir_next = CNT_IDLE;
                end
            endcase
        end
    end

    // counter state
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 16'h0000;
            dir_reg <= CNT_IDLE;
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
        end
    end

    // compare: high from zero until duty match, both types
    always_comb begin
        raw_gen = 6'h00;
        for (int i = 0; i < CHANNELS; i++) begin
            raw_gen[i] = run_reg && (cnt_next < duty_act_reg[i]);
        end
        gen_next = raw_gen;
        case (mode_reg)
            MODE_COMP: begin
                gen_next[1] = !raw_gen[0];
                gen_next[3] = !raw_gen[2];
                gen_next[5] = !raw_gen[4];
            end
            MODE_SYNC: begin
                gen_next[1] = raw_gen[0];
                gen_next[3] = raw_gen[2];
                gen_next[5] = raw_gen[4];
            end
            default: ;
        endcase
    end

    // generator outputs and shared pins, pin index equals channel number
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gen_out <= 6'h00;
            pin_out <= '0;
        end else if (ce_in) begin
            gen_out <= gen_next;
            pin_out <= (gen_next & route_reg) | (port_data_in & ~route_reg);
        end
    end

    // read mux
    always_comb begin
        rd_next = 8'h00;
        case (rsel.kind)
            SEL_PERIOD_LO: rd_next = period_lo_reg;
            SEL_PERIOD_HI: rd_next = period_hi_reg;
            SEL_DUTY_LO:   rd_next = duty_lo_reg[rsel.chan];
            SEL_DUTY_HI:   rd_next = duty_hi_reg[rsel.chan];
            SEL_ROUTE:     rd_next = {2'b00, route_reg};
            SEL_CTRL:      rd_next = {run_reg, load_pend_reg, 1'b0, clear_pend_reg, 4'h0};
            SEL_MISC:      rd_next = (rsel.chan == 3'h0) ?
                                     {mode_reg, 1'b0, type_center_reg, 4'h0} :
                                     {7'h00, page_reg};
            default:       rd_next = 8'h00;
        endcase
    end

    // read data stands the cycle after the strobe only
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
        end else if (ce_in) begin
            rd_data_out <= bus_req_in.rd ? rd_next : 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_period_lo;
        ce_in && bus_req_in.wr && bus_req_in.addr == PERIOD_LOW_OFF
        |=> period_lo_reg == $past(bus_req_in.wdata);
    endproperty
    a_period_lo: assert property (p_period_lo) else $error("period low not stored");

    property p_period_act;
        ce_in && load_apply |=> period_act_reg == $past({period_hi_reg, period_lo_reg});
    endproperty
    a_period_act: assert property (p_period_act) else $error("period not loaded");

    property p_duty_act;
        ce_in && load_apply
        |=> duty_act_reg[4] == $past({duty_hi_reg[4], duty_lo_reg[4]})
            && duty_act_reg[0] == $past({duty_hi_reg[0], duty_lo_reg[0]});
    endproperty
    a_duty_act: assert property (p_duty_act) else $error("duty not loaded");

    property p_page0_block;
        ce_in && bus_req_in.wr && !page_reg && bus_req_in.addr == CHAN4_HIGH_OFF
        |=> $stable(duty_hi_reg[4]);
    endproperty
    a_page0_block: assert property (p_page0_block) else $error("page 0 wrote channel 4");

    property p_route_pin;
        $past(ce_in) && ce_in && $past(route_reg[0]) |-> pin_out[0] == gen_out[0];
    endproperty
    a_route_pin: assert property (p_route_pin) else $error("routed pin differs");

    property p_route_pin5;
        $past(ce_in) && ce_in && $past(route_reg[5]) |-> pin_out[5] == gen_out[5];
    endproperty
    a_route_pin5: assert property (p_route_pin5) else $error("routed pin 5 differs");

    // unrouted pin carries the port latch; skip the edge right after reset
    property p_port_pin3;
        $past(rst_n_in) && $past(ce_in) && !$past(route_reg[3])
        |-> pin_out[3] == $past(port_data_in[3]);
    endproperty
    a_port_pin3: assert property (p_port_pin3) else $error("port pin 3 not passed");

    property p_route_upper;
        bus_req_in.rd && ce_in && bus_req_in.addr == ROUTE_OFF |=> rd_data_out[7:6] == 2'b00;
    endproperty
    a_route_upper: assert property (p_route_upper) else $error("route upper bits set");

    property p_load_hold;
        ce_in && load_pend_reg && run_reg && !period_end |=> load_pend_reg;
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load applied early");

    property p_edge_wrap;
        ce_in && run_reg && !clear_pend_reg && !type_center_reg && dir_reg == CNT_UP
        && cnt_reg == period_act_reg |=> cnt_reg == 16'h0000;
    endproperty
    a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter did not wrap");

    property p_center_turn;
        ce_in && run_reg && !clear_pend_reg && type_center_reg && dir_reg == CNT_UP
        && cnt_reg == period_act_reg && period_act_reg != 16'h0000 |=> dir_reg == CNT_DOWN;
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center did not turn");

    property p_comp;
        $past(ce_in) && $past(mode_reg) == MODE_COMP |-> gen_out[1] == !gen_out[0];
    endproperty
    a_comp: assert property (p_comp) else $error("pair not complementary");

    property p_readback;
        ce_in && bus_req_in.rd && bus_req_in.addr == CHAN0_LOW_OFF
        |=> rd_data_out == $past(duty_lo_reg[0]);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

endmodule : pwg_regs

/* File: hw/pwg_pkg.sv */
// shared constants, types and register map of the pwm register block
package pwg_pkg;

    localparam int          PWG_CHANNELS      = 6;
    localparam int          PWG_DATA_W        = 8;
    localparam int          PWG_ADDR_W        = 8;
    localparam int          PWG_CNT_W         = 16;

    // register offsets, default page
    localparam logic [7:0]  PERIOD_LOW_OFF    = 8'hD9;
    localparam logic [7:0]  PERIOD_HIGH_OFF   = 8'hD1;
    localparam logic [7:0]  CHAN0_LOW_OFF     = 8'hDA;
    localparam logic [7:0]  CHAN0_HIGH_OFF    = 8'hD2;
    localparam logic [7:0]  CHAN1_LOW_OFF     = 8'hDB;
    localparam logic [7:0]  CHAN1_HIGH_OFF    = 8'hD3;
    localparam logic [7:0]  CHAN2_LOW_OFF     = 8'hDC;
    localparam logic [7:0]  CHAN2_HIGH_OFF    = 8'hD4;
    localparam logic [7:0]  CHAN3_LOW_OFF     = 8'hDD;
    localparam logic [7:0]  CHAN3_HIGH_OFF    = 8'hD5;
    localparam logic [7:0]  ROUTE_OFF         = 8'hDE;
    localparam logic [7:0]  CTRL_OFF          = 8'hD8;
    localparam logic [7:0]  CONFIG_OFF        = 8'hDF;
    localparam logic [7:0]  PAGE_OFF          = 8'h9F;
    // register offsets, alternate page 1
    localparam logic [7:0]  CHAN4_LOW_OFF     = 8'hCC;
    localparam logic [7:0]  CHAN4_HIGH_OFF    = 8'hC4;
    localparam logic [7:0]  CHAN5_LOW_OFF     = 8'hCD;
    localparam logic [7:0]  CHAN5_HIGH_OFF    = 8'hC5;

    // reset values
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [5:0]  ROUTE_RESET       = 6'h00;

    // field positions
    localparam int          CTRL_RUN_BIT      = 7;
    localparam int          CTRL_LOAD_BIT     = 6;
    localparam int          CTRL_CLEAR_BIT    = 4;
    localparam int          CONFIG_MODE_LSB   = 6;
    localparam int          CONFIG_TYPE_BIT   = 4;
    localparam int          PAGE_BIT          = 0;
    localparam int          ROUTE_W           = 6;

    typedef enum logic [1:0] {
        MODE_INDEP,
        MODE_COMP,
        MODE_SYNC,
        MODE_RSVD
    } pwg_mode_e;

    typedef enum logic [1:0] {
        CNT_IDLE,
        CNT_UP,
        CNT_DOWN
    } pwg_cnt_e;

    // register selector kinds
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DUTY_LO,
        SEL_DUTY_HI,
        SEL_PERIOD_LO,
        SEL_PERIOD_HI,
        SEL_ROUTE,
        SEL_CTRL,
        SEL_MISC
    } pwg_sel_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pwg_bus_req_s;

    typedef struct packed {
        pwg_sel_e   kind;
        logic [2:0] chan;
    } pwg_sel_s;

endpackage : pwg_pkg

/* File: sim/pwg_load.sv */
// external load model: counts high cycles seen on each shared pin
`timescale 1ns/1ps
module pwg_load
    import pwg_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                clr_in,
    input  wire logic [ROUTE_W-1:0]  pin_in,
    output logic      [5:0][7:0]     high_cnt_out
);
    // per-pin high-cycle counters, cleared on request
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_cnt_out <= '0;
        end else if (clr_in) begin
            high_cnt_out <= '0;
        end else begin
            for (int i = 0; i < ROUTE_W; i++) begin
                if (pin_in[i] === 1'b1) begin
                    high_cnt_out[i] <= high_cnt_out[i] + 8'h01;
                end
            end
        end
    end
endmodule : pwg_load

/* File: sim/testbench.sv */
// self-checking bench for the pwm register block
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module testbench;
    import pwg_pkg::*;
    typedef struct packed {
        logic       page;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pwg_row_s;

    logic                ref_clk_in;
    logic                rst_n_in;
    logic                ce_in;
    pwg_bus_req_s        bus_req;
    logic [ROUTE_W-1:0]  port_data;
    logic [7:0]          rd_data_out;
    logic [5:0]          gen_out;
    logic [ROUTE_W-1:0]  pin_out;
    logic                load_clr;
    logic [5:0][7:0]     high_cnt;
    int                  n_errors;
    int                  cmp_count;
    logic [7:0]          rdv;
    int                  i;
    pwg_row_s            rows [15];
    pwg_row_s            prog [14];

    pwg_regs dut (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .bus_req_in   (bus_req),
        .port_data_in (port_data),
        .rd_data_out  (rd_data_out),
        .gen_out      (gen_out),
        .pin_out      (pin_out)
    );

    pwg_load load (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .clr_in       (load_clr),
        .pin_in       (pin_out),
        .high_cnt_out (high_cnt)
    );

    // 50 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // one register write cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge ref_clk_in);
        bus_req.wr    <= 1'b0;
    endtask : wr_reg

    // one register read cycle, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk_in);
        bus_req.rd   <= 1'b0;
        #1 d = rd_data_out;
    endtask : rd_reg

    // page select then access
    task automatic set_page(input logic p);
        wr_reg(PAGE_OFF, {7'h00, p});
    endtask : set_page

    // count pin high cycles over 40 clocks and compare per pin
    task automatic measure(input logic [5:0][7:0] exp);
        @(posedge ref_clk_in);
        load_clr <= 1'b1;
        @(posedge ref_clk_in);
        load_clr <= 1'b0;
        repeat (40) @(posedge ref_clk_in);
        #1;
        for (int c = 0; c < 6; c++) begin
            `CHK(high_cnt[c], exp[c])
        end
    endtask : measure

    // verdict and end of run
    task automatic end_sim();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        n_errors  = 0;
        cmp_count = 0;
        rst_n_in  = 1'b0;
        ce_in     = 1'b1;
        bus_req   = '0;
        port_data = 6'h2A;
        load_clr  = 1'b0;
        rows = '{
            '{1'b0, PERIOD_LOW_OFF,  8'h11, 8'h11}, '{1'b0, PERIOD_HIGH_OFF, 8'h22, 8'h22},
            '{1'b0, CHAN0_LOW_OFF,   8'h33, 8'h33}, '{1'b0, CHAN0_HIGH_OFF,  8'h44, 8'h44},
            '{1'b0, CHAN1_LOW_OFF,   8'h55, 8'h55}, '{1'b0, CHAN1_HIGH_OFF,  8'h66, 8'h66},
            '{1'b0, CHAN2_LOW_OFF,   8'h77, 8'h77}, '{1'b0, CHAN2_HIGH_OFF,  8'h88, 8'h88},
            '{1'b0, CHAN3_LOW_OFF,   8'h99, 8'h99}, '{1'b0, CHAN3_HIGH_OFF,  8'hAA, 8'hAA},
            '{1'b0, ROUTE_OFF,       8'hFF, 8'h3F}, '{1'b1, CHAN4_LOW_OFF,   8'hBB, 8'hBB},
            '{1'b1, CHAN4_HIGH_OFF,  8'hCC, 8'hCC}, '{1'b1, CHAN5_LOW_OFF,   8'hDD, 8'hDD},
            '{1'b1, CHAN5_HIGH_OFF,  8'hEE, 8'hEE}};
        // period 3, duties 2,1,3,4,0,2
        prog = '{
            '{1'b0, PERIOD_LOW_OFF, 8'h03, 8'h00}, '{1'b0, PERIOD_HIGH_OFF, 8'h00, 8'h00},
            '{1'b0, CHAN0_LOW_OFF,  8'h02, 8'h00}, '{1'b0, CHAN0_HIGH_OFF,  8'h00, 8'h00},
            '{1'b0, CHAN1_LOW_OFF,  8'h01, 8'h00}, '{1'b0, CHAN1_HIGH_OFF,  8'h00, 8'h00},
            '{1'b0, CHAN2_LOW_OFF,  8'h03, 8'h00}, '{1'b0, CHAN2_HIGH_OFF,  8'h00, 8'h00},
            '{1'b0, CHAN3_LOW_OFF,  8'h04, 8'h00}, '{1'b0, CHAN3_HIGH_OFF,  8'h00, 8'h00},
            '{1'b1, CHAN4_LOW_OFF,  8'h00, 8'h00}, '{1'b1, CHAN4_HIGH_OFF,  8'h00, 8'h00},
            '{1'b1, CHAN5_LOW_OFF,  8'h02, 8'h00}, '{1'b1, CHAN5_HIGH_OFF,  8'h00, 8'h00}};
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        `CHK(pin_out, 6'h2A)
        `CHK(gen_out, 6'h00)
        // reset value, write, read back for every period, duty and route register
        for (i = 0; i < 15; i++) begin
            set_page(rows[i].page);
            rd_reg(rows[i].addr, rdv);
            `CHK(rdv, 8'h00)
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, rdv);
            `CHK(rdv, rows[i].exp)
        end
        // page 1 duty bytes are unreachable from page 0
        set_page(1'b0);
        rd_reg(CHAN4_LOW_OFF, rdv);
        `CHK(rdv, 8'h00)
        wr_reg(CHAN4_LOW_OFF, 8'h01);
        set_page(1'b1);
        rd_reg(CHAN4_LOW_OFF, rdv);
        `CHK(rdv, 8'hBB)
        // program period and duties
        for (i = 0; i < 14; i++) begin
            set_page(prog[i].page);
            wr_reg(prog[i].addr, prog[i].wdata);
        end
        set_page(1'b0);
        // run without load: active values stay at reset zero
        wr_reg(CTRL_OFF, 8'h80);
        measure('0);
        wr_reg(CTRL_OFF, 8'hC0);
        rdv = 8'hFF;
        i   = 0;
        while (rdv[CTRL_LOAD_BIT] !== 1'b0 && i < 50) begin
            rd_reg(CTRL_OFF, rdv);
            i++;
        end
        `CHK(rdv[CTRL_LOAD_BIT], 1'b0)
        if (rdv[CTRL_LOAD_BIT] !== 1'b0) begin
            end_sim();
        end
        // even channels routed, odd pins left to the port latch (all high)
        wr_reg(ROUTE_OFF, 8'h15);
        measure({8'h28, 8'h00, 8'h28, 8'h1E, 8'h28, 8'h14});
        wr_reg(ROUTE_OFF, 8'h3F);
        measure({8'h14, 8'h00, 8'h28, 8'h1E, 8'h0A, 8'h14});
        // complementary pairing
        wr_reg(CONFIG_OFF, 8'h40);
        measure({8'h28, 8'h00, 8'h0A, 8'h1E, 8'h14, 8'h14});
        // synchronised pairing: odd outputs follow even outputs
        wr_reg(CONFIG_OFF, 8'h80);
        measure({8'h00, 8'h00, 8'h1E, 8'h1E, 8'h14, 8'h14});
        // center type, independent, counter cleared to fix the phase
        wr_reg(CONFIG_OFF, 8'h10);
        wr_reg(CTRL_OFF, 8'h90);
        measure({8'h13, 8'h00, 8'h28, 8'h21, 8'h06, 8'h13});
        // reset in mid-run: registers and pins back to reset state
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(pin_out, 6'h2A)
        `CHK(gen_out, 6'h00)
        rd_reg(PERIOD_LOW_OFF, rdv);
        `CHK(rdv, 8'h00)
        rd_reg(ROUTE_OFF, rdv);
        `CHK(rdv, 8'h00)
        end_sim();
    end
endmodule : testbench
